// [verilog/utpc_regs.vh]
// Constants for the transceiver pin controller.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef UTPC_REGS_VH
`define UTPC_REGS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define UTPC_CLK_PERIOD_PS   32'd8000
`define UTPC_SETTLE_TIME_PS  32'd300000
// Least time rounds up to whole cycles
`define UTPC_SETTLE_CYCLES   ((`UTPC_SETTLE_TIME_PS + `UTPC_CLK_PERIOD_PS - 32'd1) / \
                              `UTPC_CLK_PERIOD_PS)
`define UTPC_CNT_W           6
`define UTPC_DEPTH           4

// ----------------------------------------
// Controller states
// ----------------------------------------
`define UTPC_ST_IDLE    3'h0
`define UTPC_ST_SETTLE  3'h1
`define UTPC_ST_TX      3'h2
`define UTPC_ST_HOLD    3'h3
`define UTPC_ST_SHARE   3'h4

`endif

// [verilog/utpc_hist.v]
// Small history memory of the last received line states.
// Registered read data; written once per sampled cycle.
`timescale 1ns/100ps
`include "utpc_regs.vh"
module utpc_hist (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       wr_en,
  input  wire [2:0] wr_data,
  input  wire [1:0] rd_addr,
  output reg  [2:0] rd_data_q
);
  reg [2:0] mem [0:`UTPC_DEPTH-1];
  reg [1:0] wr_ptr_q;

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_ptr_q] <= wr_data;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q  <= 2'h0;
      rd_data_q <= 3'h0;
    end else begin
      if (wr_en) begin
        wr_ptr_q <= wr_ptr_q + 2'h1;
      end
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule // utpc_hist

// [verilog/utpc_ctrl.v]
// Controller driving a full/low-speed USB transceiver's control pins.
// Assumes transceiver pins are synchronous to CLOCK and pins are resolved outside.
`timescale 1ns/100ps
`include "utpc_regs.vh"
module utpc_ctrl (
  input  wire       CLOCK,
  input  wire       ARST_N,
  // User side
  input  wire       ATTACH_REQ,
  input  wire       SUSPEND_REQ,
  input  wire       FULL_SPEED_REQ,
  input  wire       TX_REQ,
  input  wire       TX_PLUS,
  input  wire       TX_MINUS,
  input  wire       SHARE_REQ,
  input  wire       BUS_GROUNDED,
  input  wire       IF_SUPPLY_OK,
  input  wire [1:0] HIST_ADDR,
  output reg        TX_READY,
  output reg        RX_PLUS,
  output reg        RX_MINUS,
  output reg        RX_DIFF,
  output reg        BUS_ABSENT,
  output reg        SHARE_ACTIVE,
  output reg  [2:0] HIST_DATA,
  // Transceiver side
  output reg        ATTACH_PULLUP_ENABLE,
  output reg        LOW_POWER_HOLD,
  output reg        EDGE_RATE_SELECT,
  output reg        DRIVE_DIR_N,
  input  wire       LINE_PLUS_IN,
  output reg        LINE_PLUS_OUT,
  output reg        LINE_PLUS_OE_N,
  input  wire       LINE_MINUS_IN,
  output reg        LINE_MINUS_OUT,
  output reg        LINE_MINUS_OE_N,
  input  wire       DIFF_RECEIVE_OUT
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [2:0]             state_q;
  reg [2:0]             state_d;
  reg [`UTPC_CNT_W-1:0] settle_q;
  reg [`UTPC_CNT_W-1:0] settle_d;
  wire [2:0]            hist_rd;

  localparam [31:0]            SETTLE_W = `UTPC_SETTLE_CYCLES;
  localparam [`UTPC_CNT_W-1:0] SETTLE_N = SETTLE_W[`UTPC_CNT_W-1:0];

  // Lines high with receive low while receiving means no bus supply
  wire bus_gone = DRIVE_DIR_N & LINE_PLUS_IN & LINE_MINUS_IN & ~DIFF_RECEIVE_OUT;
  wire can_talk = IF_SUPPLY_OK;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    state_d  = state_q;
    settle_d = settle_q;
    case (state_q)
      `UTPC_ST_IDLE: begin
        if (!can_talk) begin
          state_d = `UTPC_ST_IDLE;
        end else if (SHARE_REQ && !BUS_GROUNDED) begin
          state_d = `UTPC_ST_SHARE;
        end else if (SUSPEND_REQ) begin
          state_d = `UTPC_ST_HOLD;
        end else if (TX_REQ && FULL_SPEED_REQ) begin
          state_d  = `UTPC_ST_SETTLE;
          settle_d = SETTLE_N;
        end else if (TX_REQ) begin
          state_d = `UTPC_ST_TX;
        end
      end
      `UTPC_ST_SETTLE: begin
        if (!can_talk || !FULL_SPEED_REQ) begin
          state_d = `UTPC_ST_IDLE;
        end else if (settle_q <= {{(`UTPC_CNT_W-1){1'b0}}, 1'b1}) begin
          state_d = `UTPC_ST_TX;
        end else begin
          settle_d = settle_q - {{(`UTPC_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      `UTPC_ST_TX: begin
        if (!TX_REQ || !can_talk) begin
          state_d = `UTPC_ST_IDLE;
        end
      end
      `UTPC_ST_HOLD: begin
        if (!SUSPEND_REQ || !can_talk) begin
          state_d = `UTPC_ST_IDLE;
        end
      end
      `UTPC_ST_SHARE: begin
        if (!SHARE_REQ || BUS_GROUNDED || !can_talk) begin
          state_d = `UTPC_ST_IDLE;
        end
      end
      default: begin
        state_d = `UTPC_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers and pins
  // ----------------------------------------
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q              <= `UTPC_ST_IDLE;
      settle_q             <= {`UTPC_CNT_W{1'b0}};
      ATTACH_PULLUP_ENABLE <= 1'b0;
      LOW_POWER_HOLD       <= 1'b0;
      EDGE_RATE_SELECT     <= 1'b0;
      DRIVE_DIR_N          <= 1'b1;
      LINE_PLUS_OUT        <= 1'b0;
      LINE_PLUS_OE_N       <= 1'b1;
      LINE_MINUS_OUT       <= 1'b0;
      LINE_MINUS_OE_N      <= 1'b1;
      TX_READY             <= 1'b0;
      RX_PLUS              <= 1'b0;
      RX_MINUS             <= 1'b0;
      RX_DIFF              <= 1'b0;
      BUS_ABSENT           <= 1'b0;
      SHARE_ACTIVE         <= 1'b0;
      HIST_DATA            <= 3'h0;
    end else begin
      state_q  <= state_d;
      settle_q <= settle_d;
      ATTACH_PULLUP_ENABLE <= ATTACH_REQ & can_talk;
      // Hold asserted for suspend and while lines are shared
      LOW_POWER_HOLD <= (state_d == `UTPC_ST_HOLD) |
                        (state_d == `UTPC_ST_SHARE);
      // Speed selected early so settling overlaps idle; dropped in hold.
      // Frozen while sending, so a raise mid-send never skips the settle wait; a direct low-speed send keeps the level set in idle.
      if (state_d != `UTPC_ST_TX) begin
        EDGE_RATE_SELECT <= FULL_SPEED_REQ & (state_d != `UTPC_ST_HOLD) &
                            (state_d != `UTPC_ST_SHARE) & can_talk;
      end
      // Sharing needs the controller side in drive direction
      DRIVE_DIR_N <= ~((state_d == `UTPC_ST_TX) |
                       (state_d == `UTPC_ST_SHARE));
      LINE_PLUS_OUT   <= (state_d == `UTPC_ST_TX) & TX_PLUS;
      LINE_MINUS_OUT  <= (state_d == `UTPC_ST_TX) & TX_MINUS;
      LINE_PLUS_OE_N  <= ~((state_d == `UTPC_ST_TX) |
                           (state_d == `UTPC_ST_SHARE));
      LINE_MINUS_OE_N <= ~((state_d == `UTPC_ST_TX) |
                           (state_d == `UTPC_ST_SHARE));
      TX_READY     <= (state_d == `UTPC_ST_TX);
      // Receive pins stay valid in hold for activity detection
      RX_PLUS      <= DRIVE_DIR_N & LINE_PLUS_IN;
      RX_MINUS     <= DRIVE_DIR_N & LINE_MINUS_IN;
      RX_DIFF      <= DIFF_RECEIVE_OUT;
      BUS_ABSENT   <= bus_gone;
      SHARE_ACTIVE <= (state_d == `UTPC_ST_SHARE);
      HIST_DATA    <= hist_rd;
    end
  end

  // ----------------------------------------
  // Receive history
  // ----------------------------------------
  utpc_hist u_hist (
    .clk       (CLOCK),
    .arst_n    (ARST_N),
    .wr_en     (DRIVE_DIR_N),
    .wr_data   ({DIFF_RECEIVE_OUT, LINE_MINUS_IN, LINE_PLUS_IN}),
    .rd_addr   (HIST_ADDR),
    .rd_data_q (hist_rd)
  );
endmodule // utpc_ctrl

// [test/utpc_chk_asserts.sv]
// Assertions on the pin controller's ports.
// Bound into every utpc_ctrl instance.
`timescale 1ns/100ps
module utpc_chk (
  input wire CLOCK, ARST_N, ATTACH_REQ, IF_SUPPLY_OK, BUS_GROUNDED, SHARE_ACTIVE,
  input wire ATTACH_PULLUP_ENABLE, LOW_POWER_HOLD, EDGE_RATE_SELECT, DRIVE_DIR_N,
  input wire LINE_PLUS_OE_N, LINE_MINUS_OE_N
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // Cycles since edge rate went high, saturating
  reg [5:0] fs_cnt_q;
  always @(posedge CLOCK or negedge ARST_N)
    if (!ARST_N) fs_cnt_q <= 6'h00;
    else fs_cnt_q <= !EDGE_RATE_SELECT ? 6'h00 : fs_cnt_q + {5'h00, fs_cnt_q != 6'h3F};
  property p_att; $past(ARST_N) |-> ATTACH_PULLUP_ENABLE ==
    ($past(ATTACH_REQ) && $past(IF_SUPPLY_OK)); endproperty
  property p_hold; LOW_POWER_HOLD && !SHARE_ACTIVE |-> DRIVE_DIR_N && !EDGE_RATE_SELECT;
  endproperty
  // 300 ns at 8 ns is 37.5, so 38 whole cycles
  property p_set; !LINE_PLUS_OE_N && !SHARE_ACTIVE && EDGE_RATE_SELECT |-> fs_cnt_q >= 6'h26;
  endproperty
  property p_shr; SHARE_ACTIVE |-> !DRIVE_DIR_N && LOW_POWER_HOLD; endproperty
  property p_gnd; $rose(SHARE_ACTIVE) |-> !$past(BUS_GROUNDED); endproperty
  property p_dir; DRIVE_DIR_N == LINE_PLUS_OE_N && DRIVE_DIR_N == LINE_MINUS_OE_N;
  endproperty
  a_att: assert property (p_att) else $error("pull-up");
  a_hold: assert property (p_hold) else $error("hold pins");
  a_set: assert property (p_set) else $error("settle");
  a_shr: assert property (p_shr) else $error("share pins");
  a_gnd: assert property (p_gnd) else $error("grounded share");
  a_dir: assert property (p_dir) else $error("direction");
  c_shr: cover property (SHARE_ACTIVE);
  c_fs: cover property (!LINE_PLUS_OE_N && EDGE_RATE_SELECT);
  c_hold: cover property (LOW_POWER_HOLD && !SHARE_ACTIVE);
endmodule // utpc_chk
bind utpc_ctrl utpc_chk u_chk (.*);

// [test/utpc_xcvr.sv]
// Behavioural transceiver facing the controller.
// Bus supply and far line state come from the bench.
`timescale 1ns/100ps
module utpc_xcvr (
  input wire ATTACH_PULLUP_ENABLE, LOW_POWER_HOLD, EDGE_RATE_SELECT, DRIVE_DIR_N,
  input wire LINE_PLUS_OUT, LINE_PLUS_OE_N, LINE_MINUS_OUT, LINE_MINUS_OE_N,
  input wire VBUS_OK, DEV_P, DEV_M,
  output wire LINE_PLUS_IN, LINE_MINUS_IN, DIFF_RECEIVE_OUT,
  output wire PULLUP_SUPPLY_OUT, LOW_CURRENT, FAST_EDGES
);
  // Receivers are not gated by hold, so activity is still seen
  wire rx_p = VBUS_OK ? DEV_P : 1'b1;
  wire rx_m = VBUS_OK ? DEV_M : 1'b1;
  assign PULLUP_SUPPLY_OUT = ATTACH_PULLUP_ENABLE;
  assign LOW_CURRENT = LOW_POWER_HOLD;
  assign FAST_EDGES = EDGE_RATE_SELECT;
  assign DIFF_RECEIVE_OUT = VBUS_OK & rx_p & ~rx_m;
  // Undriven pin shows the far line when receiving, else the inverse of the output level
  assign LINE_PLUS_IN = !LINE_PLUS_OE_N ? LINE_PLUS_OUT : DRIVE_DIR_N ? rx_p : ~LINE_PLUS_OUT;
  assign LINE_MINUS_IN = !LINE_MINUS_OE_N ? LINE_MINUS_OUT : DRIVE_DIR_N ? rx_m : ~LINE_MINUS_OUT;
endmodule // utpc_xcvr

// [test/testbench.sv]
// Self-checking bench for the pin controller.
// A transceiver model answers on the pins.
`timescale 1ns/100ps
module testbench;
  logic CLOCK = 0, ARST_N = 0, ATTACH_REQ = 0, SUSPEND_REQ = 0, FULL_SPEED_REQ = 0;
  logic TX_REQ = 0, TX_PLUS = 0, TX_MINUS = 0, SHARE_REQ = 0, BUS_GROUNDED = 0;
  logic IF_SUPPLY_OK = 1, VBUS_OK = 1, DEV_P = 1, DEV_M = 0;
  logic [1:0] HIST_ADDR = 2'h0;
  wire TX_READY, RX_PLUS, RX_MINUS, RX_DIFF, BUS_ABSENT, SHARE_ACTIVE, LINE_PLUS_IN;
  wire [2:0] HIST_DATA;
  wire ATTACH_PULLUP_ENABLE, LOW_POWER_HOLD, EDGE_RATE_SELECT, DRIVE_DIR_N, LINE_PLUS_OUT;
  wire LINE_PLUS_OE_N, LINE_MINUS_IN, LINE_MINUS_OUT, LINE_MINUS_OE_N, DIFF_RECEIVE_OUT;
  wire PULLUP_SUPPLY_OUT, LOW_CURRENT, FAST_EDGES;
  int bad_count = 0, compares = 0;
  int n;
  utpc_ctrl dut (.*);
  utpc_xcvr xcvr (.*);
  always #4 CLOCK = ~CLOCK;
  task ck(input logic c, input string m);
    compares++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge CLOCK);
    #1;
  endtask
  task close_out;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    cyc(6);
    @(posedge CLOCK) ARST_N <= 1'b1;
    @(posedge CLOCK) {ATTACH_REQ, IF_SUPPLY_OK} <= 2'h3;
    cyc(2);
    ck(PULLUP_SUPPLY_OUT === 1'b1, "pull-up off");
    @(posedge CLOCK) {ATTACH_REQ, SUSPEND_REQ, FULL_SPEED_REQ} <= 3'h3;
    cyc(3);
    ck(PULLUP_SUPPLY_OUT === 1'b0, "pull-up on");
    ck(LOW_CURRENT === 1'b1 && EDGE_RATE_SELECT === 1'b0, "hold");
    ck(DRIVE_DIR_N === 1'b1, "hold dir");
    @(posedge CLOCK) DEV_P <= 1'b0;
    cyc(3);
    ck(RX_PLUS === 1'b0 && RX_DIFF === 1'b0, "hold rx");
    @(posedge CLOCK) {SUSPEND_REQ, TX_REQ, TX_PLUS, DEV_P} <= 4'h7;
    n = 0;
    cyc(2);
    while (TX_READY !== 1'b1 && n < 80) begin
      n++;
      cyc(1);
    end
    ck(n >= 37 && n < 80, "settle");
    ck(FAST_EDGES === 1'b1 && DRIVE_DIR_N === 1'b0, "fs drive");
    cyc(2);
    ck(LINE_PLUS_IN === 1'b1 && LINE_MINUS_IN === 1'b0, "tx data");
    @(posedge CLOCK) {FULL_SPEED_REQ, TX_REQ, SHARE_REQ, BUS_GROUNDED, VBUS_OK} <= 5'h06;
    cyc(3);
    ck(SHARE_ACTIVE === 1'b0 && LINE_PLUS_OE_N === 1'b1, "grounded");
    @(posedge CLOCK) BUS_GROUNDED <= 1'b0;
    cyc(3);
    ck(SHARE_ACTIVE === 1'b1 && LOW_POWER_HOLD === 1'b1, "share");
    ck(DRIVE_DIR_N === 1'b0, "share dir");
    @(posedge CLOCK) SHARE_REQ <= 1'b0;
    cyc(3);
    ck(BUS_ABSENT === 1'b1, "no bus");
    ck(RX_PLUS === 1'b1 && RX_MINUS === 1'b1 && RX_DIFF === 1'b0, "no bus rx");
    @(posedge CLOCK) HIST_ADDR <= 2'h2;
    cyc(3);
    ck(HIST_DATA === 3'h3, "history");
    @(posedge CLOCK) {ATTACH_REQ, IF_SUPPLY_OK} <= 2'h2;
    cyc(2);
    ck(PULLUP_SUPPLY_OUT === 1'b0, "no if supply");
    close_out;
  end
  // Run needs about 640 ns
  initial begin
    #20000;
    bad_count++;
    close_out;
  end
endmodule // testbench
